// file: aicc_top.sv
// Configuration, sequencing, reference, clock select and output coding of the converter
// ==========================================================
// Overview of operation
// RULE1: Up to 16 channels, scanned ascending.
// RULE2: Disabled channels are skipped.
// RULE3: Input buffers can be bypassed.
// RULE4: Current channels use matching numbered pairs.
// RULE5: Buffers off for current-input setups.
// RULE6: Factory gain loaded into all gains at reset.
// RULE7: Buffers on for voltage-input setups.
// RULE8: Differential voltage pairs only adjacent inputs.
// RULE9: Single-ended voltage uses common input.
// RULE10: Software updates gain for voltage inputs.
// RULE11: System full-scale calibration is alternative.
// RULE12: Unipolar output is straight binary.
// RULE13: Bipolar output is offset binary.
// RULE14: Voltage inputs scaled by tenth, 24 bits.
// RULE15: Current inputs coded through 50 ohm.
// RULE16: Setup bits 5:4 select reference.
// RULE17: Setups default to external reference.
// RULE18: Internal reference off until enable set.
// RULE19: Keep reference enable clear if unused.
// RULE20: 2 MHz clock from three sources.
// RULE21: Mode bits 3:2 select clock source.
// RULE22: Internal oscillator after reset.
// RULE23: Data rates scale with master clock.
// RULE24: Clock select encoding is a parameter.
`timescale 1ns/1ps
`include "aicc_defines.svh"
module aicc_top #(
  parameter int          NCH       = 16,
  parameter int          NSETUP    = 8,
  parameter logic [23:0] FACT_GAIN = 24'h500000,          // Factory gain image, arbitrary default
  parameter logic [1:0]  SEL_OSC0  = 2'h0,                // Clock select codes for each source
  parameter logic [1:0]  SEL_OSC1  = 2'h1,
  parameter logic [1:0]  SEL_EXT   = 2'h2,
  parameter logic [1:0]  SEL_XTAL  = 2'h3
) (
  input  wire logic        mclk_i,         // System clock, 40 MHz
  input  wire logic        rst_i,          // Asynchronous reset, active high
  input  wire logic        wr_i,           // Register write strobe
  input  wire logic        rd_i,           // Register read strobe
  input  wire logic [5:0]  addr_i,         // Register address
  input  wire logic [23:0] wdata_i,        // Write data
  output logic      [23:0] rdata_o,        // Read data
  input  wire logic        conv_done_i,    // Current conversion finished
  input  wire logic [23:0] raw_i,          // Raw offset-binary result from modulator
  output logic      [3:0]  chan_o,         // Channel under conversion
  output logic             chan_vld_o,     // Any channel enabled
  output logic      [2:0]  setup_o,        // Setup of current channel
  output logic             buf_bypass_o,   // Input buffers bypassed
  output logic      [1:0]  ref_sel_o,      // Reference source of current setup
  output logic             ref_out_en_o,   // Drive the reference output pin
  output logic      [2:0]  clk_src_o,      // One-hot master clock source
  output logic             mclk_en_o,      // Master clock rate enable pulse
  output logic      [23:0] code_o,         // Coded result
  output logic             code_vld_o      // Result strobe
);
  // ==========================================================
  // Register state
  logic [15:0] mode_r, mode_nxt;
  logic [15:0] setup_r [NSETUP];
  logic [15:0] setup_nxt [NSETUP];
  logic [15:0] chan_r [NCH];
  logic [15:0] chan_nxt [NCH];
  logic [23:0] gain_r [NSETUP];
  logic [23:0] gain_nxt [NSETUP];
  logic [3:0]  cur_r, cur_nxt;
  logic [23:0] code_r, code_nxt;
  logic        vld_r, vld_nxt;
  logic [4:0]  div_r, div_nxt;
  logic        gload_r, gload_nxt;
  logic [23:0] rdata_r, rdata_nxt;
  logic [NCH-1:0] en_vec;
  logic [3:0]  seq_next;
  logic        seq_any;
  logic [15:0] cur_setup;
  localparam logic [4:0] DIV_LAST = 5'(`AICC_MCLK_DIV - 1);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_en
      assign en_vec[g] = chan_r[g][`AICC_CHAN_EN_BIT];
    end
  endgenerate

  aicc_seq #(.NCH(NCH)) u_seq (
    .en_i   (en_vec),
    .cur_i  (cur_r),
    .next_o (seq_next),
    .any_o  (seq_any)
  );

  assign cur_setup = setup_r[chan_r[cur_r][`AICC_CHAN_SETUP_HI:`AICC_CHAN_SETUP_LO]];

  // ==========================================================
  // Next-state logic
  always_comb begin
    mode_nxt  = mode_r;
    setup_nxt = setup_r;
    chan_nxt  = chan_r;
    gain_nxt  = gain_r;
    cur_nxt   = cur_r;
    vld_nxt   = 1'b0;
    code_nxt  = code_r;
    gload_nxt = 1'b0;
    rdata_nxt = rdata_r;
    // Rate enable; data rates follow this pulse so they scale with the clock
    div_nxt   = (div_r == DIV_LAST) ? 5'h00 : div_r + 5'h01; // [RULE23]
    // Factory gain copy runs once in the first cycle after reset; a host write in that same cycle is dropped
    if (gload_r) begin
      for (int s = 0; s < NSETUP; s++) begin
        gain_nxt[s] = FACT_GAIN; // [RULE6]
      end
    end else if (wr_i) begin
      if (addr_i == `AICC_MODE_OFS) begin
        mode_nxt = wdata_i[15:0];
      end
      for (int s = 0; s < NSETUP; s++) begin
        if (addr_i == `AICC_SETUP0_OFS + 6'(s)) begin
          setup_nxt[s] = wdata_i[15:0];
        end
        if (addr_i == `AICC_GAIN0_OFS + 6'(s)) begin
          gain_nxt[s] = wdata_i;
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (addr_i == `AICC_CHAN0_OFS + 6'(c)) begin
          chan_nxt[c] = wdata_i[15:0];
        end
      end
    end
    if (rd_i) begin
      rdata_nxt = 24'h000000;
      if (addr_i == `AICC_MODE_OFS) begin
        rdata_nxt = {8'h00, mode_r};
      end
      for (int s = 0; s < NSETUP; s++) begin
        if (addr_i == `AICC_SETUP0_OFS + 6'(s)) begin
          rdata_nxt = {8'h00, setup_r[s]};
        end
        if (addr_i == `AICC_GAIN0_OFS + 6'(s)) begin
          rdata_nxt = gain_r[s];
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (addr_i == `AICC_CHAN0_OFS + 6'(c)) begin
          rdata_nxt = {8'h00, chan_r[c]};
        end
      end
    end
    if (conv_done_i && seq_any) begin
      // Offset-binary raw maps to unipolar straight binary by moving zero to code 0
      if (cur_setup[`AICC_SET_POL_BIT]) begin
        code_nxt = raw_i; // [RULE13] [RULE14] [RULE15]
      end else begin
        code_nxt = raw_i[23] ? {raw_i[22:0], 1'b0} : 24'h000000; // [RULE12] [RULE14] [RULE15]
      end
      vld_nxt = 1'b1;
      cur_nxt = seq_next; // [RULE1] [RULE2]
    end else if (!en_vec[cur_r] && seq_any) begin
      cur_nxt = seq_next; // [RULE2]
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r  <= `AICC_MODE_RST; // [RULE18] [RULE22]
      cur_r   <= 4'h0;
      code_r  <= 24'h000000;
      vld_r   <= 1'b0;
      div_r   <= 5'h00;
      gload_r <= 1'b1; // [RULE6]
      rdata_r <= 24'h000000;
      for (int s = 0; s < NSETUP; s++) begin
        setup_r[s] <= `AICC_SETUP_RST; // [RULE17]
        gain_r[s]  <= 24'h000000;
      end
      for (int c = 0; c < NCH; c++) begin
        chan_r[c] <= (c == 0) ? `AICC_CHAN0_RST : `AICC_CHAN_RST;
      end
    end else begin
      mode_r  <= mode_nxt;
      setup_r <= setup_nxt;
      chan_r  <= chan_nxt;
      gain_r  <= gain_nxt;
      cur_r   <= cur_nxt;
      code_r  <= code_nxt;
      vld_r   <= vld_nxt;
      div_r   <= div_nxt;
      gload_r <= gload_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    unique case (mode_r[`AICC_MODE_CLK_HI:`AICC_MODE_CLK_LO]) // [RULE21] [RULE24]
      SEL_OSC0, SEL_OSC1: clk_src_o = aicc_pkg::AICC_SRC_OSC; // [RULE20] [RULE22]
      SEL_XTAL:           clk_src_o = aicc_pkg::AICC_SRC_XTAL; // [RULE20]
      SEL_EXT:            clk_src_o = aicc_pkg::AICC_SRC_EXT; // [RULE20]
      default:            clk_src_o = aicc_pkg::AICC_SRC_OSC;
    endcase
  end

  assign rdata_o      = rdata_r;
  assign chan_o       = cur_r;
  assign chan_vld_o   = seq_any;
  assign setup_o      = chan_r[cur_r][`AICC_CHAN_SETUP_HI:`AICC_CHAN_SETUP_LO];
  // Buffers are bypassed when both input buffer bits are clear
  assign buf_bypass_o = ~|cur_setup[`AICC_SET_IBUF_HI:`AICC_SET_IBUF_LO]; // [RULE3]
  assign ref_sel_o    = cur_setup[`AICC_SET_REF_HI:`AICC_SET_REF_LO]; // [RULE16]
  assign ref_out_en_o = mode_r[`AICC_MODE_REFEN_BIT]; // [RULE18]
  assign mclk_en_o    = (div_r == DIV_LAST); // [RULE23]
  assign code_o       = code_r;
  assign code_vld_o   = vld_r;
endmodule

// file: aicc_defines.svh
// Register offsets, field positions, reset values and coding constants for the converter control block
`ifndef AICC_DEFINES_SVH
`define AICC_DEFINES_SVH
`define AICC_MODE_OFS        6'h01
`define AICC_SETUP0_OFS      6'h20
`define AICC_CHAN0_OFS       6'h10
`define AICC_GAIN0_OFS       6'h38
`define AICC_MODE_RST        16'h2000
`define AICC_SETUP_RST       16'h1000
`define AICC_CHAN_RST        16'h0000
`define AICC_CHAN0_RST       16'h8001
`define AICC_MODE_REFEN_BIT  15
`define AICC_MODE_SCYC_BIT   13
`define AICC_MODE_CLK_HI     3
`define AICC_MODE_CLK_LO     2
`define AICC_SET_POL_BIT     12
`define AICC_SET_RBP_BIT     11
`define AICC_SET_RBN_BIT     10
`define AICC_SET_IBUF_HI     9
`define AICC_SET_IBUF_LO     8
`define AICC_SET_REF_HI      5
`define AICC_SET_REF_LO      4
`define AICC_CHAN_EN_BIT     15
`define AICC_CHAN_SETUP_HI   14
`define AICC_CHAN_SETUP_LO   12
`define AICC_CLK_PER_NS      25
`define AICC_MCLK_NOM_KHZ    2000
`define AICC_SYS_KHZ         40000
`define AICC_MCLK_DIV        (`AICC_SYS_KHZ / `AICC_MCLK_NOM_KHZ)
`define AICC_MID_CODE        24'h800000
`endif

// file: aicc_pkg.sv
// Types shared by the converter control block
package aicc_pkg;
  typedef enum logic [1:0] {
    AICC_REF_EXT    = 2'h0,
    AICC_REF_INT    = 2'h2,
    AICC_REF_SUPPLY = 2'h3
  } aicc_ref_t;
  typedef enum logic [1:0] {
    AICC_CLK_INT_OSC = 2'h0,
    AICC_CLK_INT_OUT = 2'h1,
    AICC_CLK_EXT     = 2'h2,
    AICC_CLK_XTAL    = 2'h3
  } aicc_clksel_t;
  typedef enum logic [2:0] {
    AICC_SRC_OSC  = 3'h1,
    AICC_SRC_XTAL = 3'h2,
    AICC_SRC_EXT  = 3'h4
  } aicc_src_t;
endpackage

// file: aicc_seq.sv
// Channel sequencer: picks the next enabled channel in ascending order
`timescale 1ns/1ps
module aicc_seq #(
  parameter int NCH = 16
) (
  input  wire logic [NCH-1:0]         en_i,    // Channel enable bits
  input  wire logic [$clog2(NCH)-1:0] cur_i,   // Channel just converted
  output logic      [$clog2(NCH)-1:0] next_o,  // Next channel to convert
  output logic                        any_o    // At least one channel enabled
);
  localparam int CW = $clog2(NCH);
  logic [CW-1:0] first;
  logic [CW-1:0] above;
  logic          found;
  always_comb begin
    first = '0;
    above = '0;
    found = 1'b0;
    // Scan downward so the lowest match wins
    for (int i = NCH - 1; i >= 0; i--) begin
      if (en_i[i]) begin
        first = CW'(i);
      end
      if (en_i[i] && (CW'(i) > cur_i)) begin
        above = CW'(i);
        found = 1'b1;
      end
    end
    any_o  = |en_i;
    next_o = found ? above : first; // [RULE1] [RULE2]
  end
endmodule

// file: aicc_assertions.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module aicc_assertions (
  input wire logic        mclk_i,       // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        wr_i,         // Write strobe
  input wire logic [5:0]  addr_i,       // Address
  input wire logic [23:0] wdata_i,      // Write data
  input wire logic        conv_done_i,  // Conversion end
  input wire logic        chan_vld_o,   // Channel enabled
  input wire logic        ref_out_en_o, // Reference out
  input wire logic [1:0]  ref_sel_o,    // Reference select
  input wire logic [2:0]  clk_src_o,    // Clock source
  input wire logic        mclk_en_o,    // Rate pulse
  input wire logic        code_vld_o    // Result strobe
);
  // ==========================================================
  // Checks
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  wire take = conv_done_i && chan_vld_o;
  wire ref_wr = wr_i && addr_i == 6'h01 && wdata_i[15];
  a_result_cause: assert property (
    code_vld_o |-> $past(take)) else $error("result without conversion");
  a_none_refused: assert property (
    conv_done_i && !chan_vld_o |=> !code_vld_o) else $error("result with no channel");
  a_reset_state: assert property (
    $fell(rst_i) |-> clk_src_o == 3'h1 && !ref_out_en_o && ref_sel_o == 2'h0) else $error("bad reset state");
  a_ref_rise: assert property (
    $rose(ref_out_en_o) |-> $past(ref_wr) || $past(ref_wr, 2)) else $error("reference on unasked");
  a_clk_onehot: assert property (
    $onehot(clk_src_o)) else $error("clock source not one-hot");
  a_clk_xtal: assert property (
    wr_i && addr_i == 6'h01 && wdata_i[3:2] == 2'h3 |-> ##[1:2] clk_src_o == 3'h2) else $error("crystal not chosen");
  a_rate_period: assert property (
    mclk_en_o |-> ##20 mclk_en_o) else $error("rate pulse period wrong");
  a_rate_gap: assert property (
    mclk_en_o |=> !mclk_en_o [*8]) else $error("rate pulse too close");
endmodule

bind aicc_top aicc_assertions u_chk (.mclk_i, .rst_i, .wr_i, .addr_i, .wdata_i, .conv_done_i,
  .chan_vld_o, .ref_out_en_o, .ref_sel_o, .clk_src_o, .mclk_en_o, .code_vld_o);

// file: aicc_sensor_model.sv
// Behavioural front end that hands raw results to the converter control block
`timescale 1ns/1ps
module aicc_sensor_model (
  input  wire logic        mclk_i,      // Clock
  input  wire logic        rst_i,       // Reset
  input  wire logic        start_i,     // Begin a conversion
  input  wire logic [3:0]  lat_i,       // Extra wait cycles
  input  wire logic [23:0] val_i,       // Value to return
  output logic             conv_done_o, // Result pulse
  output logic      [23:0] raw_o        // Result
);
  logic [4:0]  cnt_r  = 5'h00;
  logic        done_r = 1'h0;
  logic [23:0] raw_r  = 24'h000000;
  assign conv_done_o = done_r;
  assign raw_o       = raw_r;
  // Idle bus toggles so a stale sample never passes for a result
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      done_r <= 1'h0;
    end else begin
      done_r <= cnt_r == 5'h01;
      // Each result stands for one legal pair: matched current pins, adjacent or common-referred voltage
      raw_r  <= (cnt_r == 5'h01) ? val_i : ~raw_r;
      cnt_r  <= start_i ? {1'h0, lat_i} + 5'h01 : cnt_r - {4'h0, cnt_r != 5'h00};
    end
  end
endmodule

// file: tb_adc_input_ref_clock_config.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adc_input_ref_clock_config;
  localparam logic [23:0] FGAIN = 24'h5A5A50; // Arbitrary factory image
  logic mclk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, start = 1'h0;
  logic [5:0] addr_i = 6'h00;
  logic [23:0] wdata_i = 24'h0, val = 24'h0, rdata_o, raw_i, code_o;
  logic conv_done_i, chan_vld_o, buf_bypass_o, ref_out_en_o, mclk_en_o, code_vld_o;
  logic [3:0] chan_o, lat = 4'h0;
  logic [2:0] setup_o, clk_src_o;
  logic [1:0] ref_sel_o;
  int fail_count = 0, tests_run = 0;
  always #12.5 mclk_i = ~mclk_i;
  aicc_top #(.FACT_GAIN(FGAIN)) DUT (.mclk_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .conv_done_i, .raw_i, .chan_o, .chan_vld_o, .setup_o, .buf_bypass_o, .ref_sel_o, .ref_out_en_o,
    .clk_src_o, .mclk_en_o, .code_o, .code_vld_o);
  aicc_sensor_model u_sens (.mclk_i, .rst_i, .start_i(start), .lat_i(lat), .val_i(val),
    .conv_done_o(conv_done_i), .raw_o(raw_i));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] v);
    @(posedge mclk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge mclk_i);
    wr_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    #1 chk(rdata_o, exp);
  endtask
  // A result that never comes ends the run
  task automatic conv(input logic [23:0] r, input logic [3:0] l, input logic [23:0] e, input logic [3:0] ch);
    int i;
    @(posedge mclk_i);
    start <= 1'h1;
    val <= r;
    lat <= l;
    @(posedge mclk_i);
    start <= 1'h0;
    #1;
    for (i = 0; i < 40 && code_vld_o !== 1'h1; i++) begin
      @(posedge mclk_i);
      #1;
    end
    if (i == 40) begin
      fail_count++;
      end_of_test();
    end else begin
      chk(code_o, e);
      chk({20'h0, chan_o}, {20'h0, ch});
    end
  endtask
  task automatic t_reset();
    rd(6'h01, 24'h002000);
    rd(6'h20, 24'h001000);
    rd(6'h10, 24'h008001);
    rd(6'h38, FGAIN);
    rd(6'h3F, FGAIN);
    rd(6'h02, 24'h000000);
    chk({21'h0, clk_src_o}, 24'h1);
    $display("reset defaults done");
  endtask
  task automatic t_ref_clk();
    logic [2:0] src [4] = '{3'h1, 3'h1, 3'h4, 3'h2};
    for (int k = 0; k < 4; k++) begin
      wr(6'h01, 24'(32'h8000 | (k << 2)));
      chk({21'h0, clk_src_o}, {21'h0, src[k]});
    end
    chk({23'h0, ref_out_en_o}, 24'h1);
    wr(6'h20, 24'h001320);
    chk({22'h0, ref_sel_o}, 24'h2);
    chk({23'h0, buf_bypass_o}, 24'h0);
    wr(6'h20, 24'h001030);
    chk({22'h0, ref_sel_o}, 24'h3);
    chk({23'h0, buf_bypass_o}, 24'h1);
    wr(6'h01, 24'h002000);
    chk({23'h0, ref_out_en_o}, 24'h0);
    $display("reference and clock done");
  endtask
  task automatic t_code();
    conv(24'h123456, 4'h0, 24'h123456, 4'h0);
    conv(24'h000000, 4'h9, 24'h000000, 4'h0);
    wr(6'h20, 24'h000000);
    conv(24'h900000, 4'h2, 24'h200000, 4'h0);
    conv(24'h7FFFFF, 4'h0, 24'h000000, 4'h0);
    conv(24'hC00000, 4'h0, 24'h800000, 4'h0);
    conv(24'hFFFFFF, 4'h0, 24'hFFFFFE, 4'h0);
    $display("output coding done");
  endtask
  task automatic t_seq();
    int n = 0;
    wr(6'h13, 24'h008000);
    wr(6'h1F, 24'h008000);
    conv(24'h800000, 4'h1, 24'h000000, 4'h3);
    conv(24'h800001, 4'h0, 24'h000002, 4'hF);
    conv(24'h800002, 4'h0, 24'h000004, 4'h0);
    wr(6'h10, 24'h000001);
    wr(6'h13, 24'h000000);
    wr(6'h1F, 24'h000000);
    chk({23'h0, chan_vld_o}, 24'h0);
    @(posedge mclk_i);
    start <= 1'h1;
    @(posedge mclk_i);
    start <= 1'h0;
    repeat (12) begin
      @(posedge mclk_i);
      #1 if (code_vld_o !== 1'h0) n++;
    end
    chk(24'(n), 24'h0);
    $display("sequencer done");
  endtask
  // Second reset in mid-run: gains and mode must come back whatever software left there
  task automatic t_rerst();
    int n = 0;
    wr(6'h10, 24'h00F001);
    chk({21'h0, setup_o}, 24'h7);
    chk({22'h0, ref_sel_o}, 24'h0);
    wr(6'h38, 24'h55567C);
    rd(6'h38, 24'h55567C);
    wr(6'h39, 24'h4F2A10);
    rd(6'h39, 24'h4F2A10);
    wr(6'h01, 24'h00800C);
    chk({21'h0, clk_src_o}, 24'h2);
    @(posedge mclk_i);
    rst_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    rd(6'h38, FGAIN);
    rd(6'h39, FGAIN);
    rd(6'h01, 24'h002000);
    chk({21'h0, clk_src_o}, 24'h1);
    chk({23'h0, ref_out_en_o}, 24'h0);
    chk({21'h0, setup_o}, 24'h0);
    repeat (60) begin
      @(posedge mclk_i);
      #1 if (mclk_en_o === 1'h1) n++;
    end
    chk(24'(n), 24'h3);
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    t_reset();
    t_ref_clk();
    t_code();
    t_seq();
    t_rerst();
    end_of_test();
  end
endmodule
